// >>> shared/rsc_pkg.sv
/*
 * Constants shared by the reset source controller: register addresses,
 * bit positions, reset values and timing counts.
 * Assumes the system clock and core_clk are one and the same 125 MHz clock.
 */
package rsc_pkg;

    // Register addresses on the special-function register port
    localparam logic [7:0] SMC_ADDR        = 8'hFF;
    localparam logic [7:0] RCR_ADDR        = 8'hEF;

    // Supply monitor control fields
    localparam int         SMC_EN_BIT      = 7;
    localparam int         SMC_STAT_BIT    = 6;
    localparam int         SMC_LVL_BIT     = 5;
    localparam logic [4:0] SMC_UNUSED_VAL  = 5'h00;

    // Reset cause register fields
    localparam int         RCR_PIN_BIT     = 0;
    localparam int         RCR_POR_BIT     = 1;
    localparam int         RCR_CLKLOSS_BIT = 2;
    localparam int         RCR_WDOG_BIT    = 3;
    localparam int         RCR_SW_BIT      = 4;
    localparam int         RCR_CMP_BIT     = 5;
    localparam int         RCR_FERR_BIT    = 6;
    localparam int         NUM_CAUSES      = 7;

    // Reset values
    localparam logic [NUM_CAUSES-1:0] CAUSE_POR = 7'h02;
    localparam logic       MON_EN_POR      = 1'b1;
    localparam logic       VDD_SEL_POR     = 1'b1;
    localparam logic       LVL_RST         = 1'b0;
    localparam logic       CLKLOSS_EN_RST  = 1'b0;
    localparam logic       CMP_EN_RST      = 1'b0;

    // Timing
    localparam int         CLK_PERIOD_PS   = 8000;
    localparam int         RESET_HOLD_NS   = 80;
    localparam int         RESET_HOLD_CYCLES =
        (RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int         CLKLOSS_TIMEOUT_NS = 100000;
    localparam int         CLKLOSS_TIMEOUT_CYCLES =
        (CLKLOSS_TIMEOUT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int         WDOG_PRESCALE   = 12;
    localparam int         WDOG_TICKS      = 256;

    typedef enum logic {ST_HOLD, ST_RUN} rsc_state_t;

endpackage : rsc_pkg

// >>> logic/rsc_mcd.sv
/*
 * Missing clock detector: a retriggerable one-shot fed by the sampled
 * system clock level. Assumes clk_level is synchronous to core_clk.
 */
`timescale 1ns/1ps
module rsc_clkloss #(
    parameter int TIMEOUT_CYCLES = rsc_pkg::CLKLOSS_TIMEOUT_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic enable,
    input  wire logic clk_level,
    output logic      timeout
);
    import rsc_pkg::*;

    localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
    localparam logic [CW-1:0] LIMIT = CW'(TIMEOUT_CYCLES);

    logic          level_reg;
    logic [CW-1:0] stall_reg;
    logic          timeout_reg;
    wire           edge_seen = clk_level != level_reg;
    wire           expired   = enable && !edge_seen && (stall_reg == LIMIT);

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            level_reg <= 1'b0;
        else
            level_reg <= clk_level;
    end

    // Every edge of the watched clock retriggers the one-shot
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            stall_reg <= '0;
        else if (!enable || edge_seen || expired)
            stall_reg <= '0;
        else
            stall_reg <= stall_reg + CW'(1);
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            timeout_reg <= 1'b0;
        else
            timeout_reg <= expired;
    end

    assign timeout = timeout_reg;

endmodule : rsc_clkloss

// >>> logic/rsc_wdog.sv
/*
 * Watchdog: prescaler of system clock by twelve and an expiry counter.
 * Assumes restart is held high for the whole system reset.
 */
`timescale 1ns/1ps
module rsc_wdog #(
    parameter int TICKS = rsc_pkg::WDOG_TICKS
) (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic restart,
    input  wire logic service,
    input  wire logic disable_req,
    output logic      enabled,
    output logic      expire
);
    import rsc_pkg::*;

    localparam int PW = $clog2(WDOG_PRESCALE);
    localparam int TW = $clog2(TICKS + 1);
    localparam logic [PW-1:0] PRE_LAST  = PW'(WDOG_PRESCALE - 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICKS - 1);

    logic          en_reg;
    logic [PW-1:0] pre_reg;
    logic [TW-1:0] tick_reg;
    logic          expire_reg;
    wire           tick = en_reg && (pre_reg == PRE_LAST);
    wire           over = tick && (tick_reg == TICK_LAST) && !service;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            en_reg <= 1'b1;
        else if (restart)
            en_reg <= 1'b1;
        else if (disable_req)
            en_reg <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            pre_reg <= '0;
        else if (restart || !en_reg || pre_reg == PRE_LAST)
            pre_reg <= '0;
        else
            pre_reg <= pre_reg + PW'(1);
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            tick_reg <= '0;
        else if (restart || !en_reg || service || over)
            tick_reg <= '0;
        else if (tick)
            tick_reg <= tick_reg + TW'(1);
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            expire_reg <= 1'b0;
        else
            expire_reg <= over && !restart;
    end

    assign enabled = en_reg;
    assign expire  = expire_reg;

endmodule : rsc_wdog

// >>> logic/rsc_top.sv
/*
 * Reset source controller: supply monitor control, reset cause register,
 * source combining, reset hold and reset pin drive.
 * Assumes all inputs are synchronous to core_clk and rst_b is power-on.
 */
`timescale 1ns/1ps
// Summary of operation
// - Monitor enable at bit 7; monitor resets only when also selected.
// - Bit 6 reads live monitor output, 1 above threshold.
// - Bit 5 picks threshold, 0 low, 1 high; resets to 0.
// - Monitor register bits 4:0 read zero, writes ignored.
// - Low reset pin resets the device; pin flag bit 0 set on exit.
// - Missing clock one-shot expires on a stuck clock and resets.
// - Cause bit 2 reads missing-clock flag; written value enables detector.
// - Internal resets other than power-on and the supply monitor leave the reset pin undriven.
// - Cause bit 5 write 1 enables comparator reset when output low.
// - Cause bit 5 reads 1 only after a comparator reset.
// - Watchdog enabled, clocked by system clock over twelve, after any reset.
// - Watchdog expiry resets device and sets watchdog flag.
// - Illegal flash access or security refusal resets device.
// - Flash access resets unless monitor high, enabled and selected.
// - Flash error reset sets flag at bit 6.
// - Writing 1 to bit 4 forces reset; bit reads 1 afterwards.
// - Power-on and supply monitor resets set bit 1; other resets clear it.
// - Watchdog flag at bit 3, read only.
// - Power-on enables monitor; other resets keep its enable.
// - Writing bit 1 selects monitor as reset source.
module rsc_top #(
    parameter int CLKLOSS_TIMEOUT = rsc_pkg::CLKLOSS_TIMEOUT_CYCLES,
    parameter int WDOG_TICKS      = rsc_pkg::WDOG_TICKS
) (
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    input  wire logic       rst_pin_in,
    output logic            rst_pin_out,
    output logic            rst_pin_oe,
    input  wire logic       supply_above_threshold,
    output logic            supply_monitor_enable,
    output logic            monitor_threshold_select,
    input  wire logic       comparator_out,
    input  wire logic       system_clock_level,
    input  wire logic       wdog_service,
    input  wire logic       wdog_disable,
    output logic            watchdog_enabled,
    input  wire logic       flash_access,
    input  wire logic       flash_illegal,
    output logic            sys_reset
);
    import rsc_pkg::*;

    localparam int HW = $clog2(RESET_HOLD_CYCLES + 1);
    localparam logic [HW-1:0] HOLD_LOAD = HW'(RESET_HOLD_CYCLES);

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] reg_addr);
        addr_hit = (a == reg_addr);
    endfunction : addr_hit

    // Lowest index wins: pin, supply, clock, watchdog, software, comparator, flash
    function automatic logic [NUM_CAUSES-1:0] pick_first(input logic [NUM_CAUSES-1:0] r);
        logic [NUM_CAUSES-1:0] one;
        one = '0;
        for (int i = NUM_CAUSES - 1; i >= 0; i--)
        begin
            if (r[i])
                one = NUM_CAUSES'(1) << i;
        end
        pick_first = one;
    endfunction : pick_first

    rsc_state_t              state_reg;
    rsc_state_t              state_next;
    logic [HW-1:0]           hold_cnt_reg;
    logic [HW-1:0]           hold_cnt_next;
    logic [NUM_CAUSES-1:0]   cause_reg;
    logic [NUM_CAUSES-1:0]   cause_next;
    logic [NUM_CAUSES-1:0]   flags_reg;
    logic [NUM_CAUSES-1:0]   flags_next;
    logic                    mon_en_reg;
    logic                    lvl_reg;
    logic                    vdd_sel_reg;
    logic                    clkloss_en_reg;
    logic                    cmp_en_reg;
    logic                    pin_oe_reg;
    logic                    pin_out_reg;
    logic                    sys_reset_reg;
    logic [7:0]              rdata_reg;
    logic                    clkloss_timeout;
    logic                    wdog_expire;
    logic                    wdog_en;

    wire running   = (state_reg == ST_RUN);
    wire in_hold   = (state_reg == ST_HOLD);
    wire sel_smc   = addr_hit(sfr_addr, SMC_ADDR);
    wire sel_rcr   = addr_hit(sfr_addr, RCR_ADDR);
    wire wr_smc    = running && sfr_wr && sel_smc;
    wire wr_rcr    = running && sfr_wr && sel_rcr;

    // Our own drive on the pin must not read back as an external reset
    wire req_pin   = !rst_pin_in && !pin_oe_reg;
    wire req_vdd   = mon_en_reg && vdd_sel_reg && !supply_above_threshold;
    wire req_clkloss = running && clkloss_timeout;
    wire req_wdog  = running && wdog_expire;
    wire req_sw    = wr_rcr && sfr_wdata[RCR_SW_BIT];
    wire req_cmp   = running && cmp_en_reg && !comparator_out;
    wire flash_ok  = mon_en_reg && lvl_reg && vdd_sel_reg;
    wire req_ferr  = running && (flash_illegal || (flash_access && !flash_ok));

    wire [NUM_CAUSES-1:0] req_vec;
    assign req_vec[RCR_PIN_BIT]  = req_pin;
    assign req_vec[RCR_POR_BIT]  = req_vdd;
    assign req_vec[RCR_CLKLOSS_BIT] = req_clkloss;
    assign req_vec[RCR_WDOG_BIT] = req_wdog;
    assign req_vec[RCR_SW_BIT]   = req_sw;
    assign req_vec[RCR_CMP_BIT]  = req_cmp;
    assign req_vec[RCR_FERR_BIT] = req_ferr;

    wire                  any_req    = |req_vec;
    wire [NUM_CAUSES-1:0] first_req  = pick_first(req_vec);
    // Level sources keep the device in reset past the minimum hold
    wire                  hold_level = req_pin || req_vdd;
    wire                  enter      = running && any_req;
    wire                  leave      = in_hold && (hold_cnt_reg == '0) && !hold_level;

    wire [7:0] smc_read = {mon_en_reg, supply_above_threshold, lvl_reg, SMC_UNUSED_VAL};
    wire [7:0] rcr_read = {1'b0, flags_reg};
    wire [7:0] rd_mux   = sel_smc ? smc_read : (sel_rcr ? rcr_read : 8'h00);

    always_comb
    begin
        state_next    = state_reg;
        hold_cnt_next = hold_cnt_reg;
        cause_next    = cause_reg;
        flags_next    = flags_reg;
        case (state_reg)
            ST_RUN:
            begin
                if (enter)
                begin
                    state_next    = ST_HOLD;
                    hold_cnt_next = HOLD_LOAD;
                    cause_next    = first_req;
                end
            end
            ST_HOLD:
            begin
                if (hold_cnt_reg != '0)
                    hold_cnt_next = hold_cnt_reg - HW'(1);
                if (leave)
                begin
                    state_next = ST_RUN;
                    flags_next = cause_reg;
                end
            end
            default:
            begin
                state_next = ST_HOLD;
                hold_cnt_next = HOLD_LOAD;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg    <= ST_HOLD;
            hold_cnt_reg <= HOLD_LOAD;
            cause_reg    <= CAUSE_POR;
            flags_reg    <= '0;
        end
        else
        begin
            state_reg    <= state_next;
            hold_cnt_reg <= hold_cnt_next;
            cause_reg    <= cause_next;
            flags_reg    <= flags_next;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            sys_reset_reg <= 1'b1;
        else
            sys_reset_reg <= (state_next == ST_HOLD);
    end

    // Pin driven low only for power-on and supply monitor resets
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            pin_oe_reg <= 1'b1;
        else
            pin_oe_reg <= (state_next == ST_HOLD) && cause_next[RCR_POR_BIT];
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            pin_out_reg <= 1'b0;
        else
            pin_out_reg <= 1'b0;
    end

    // Monitor enable survives every reset but power-on
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            mon_en_reg <= MON_EN_POR;
        else if (wr_smc)
            mon_en_reg <= sfr_wdata[SMC_EN_BIT];
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            lvl_reg <= LVL_RST;
        else if (enter)
            lvl_reg <= LVL_RST;
        else if (wr_smc)
            lvl_reg <= sfr_wdata[SMC_LVL_BIT];
    end

    // Selection kept across non power-on resets, like the enable
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            vdd_sel_reg <= VDD_SEL_POR;
        else if (wr_rcr)
            vdd_sel_reg <= sfr_wdata[RCR_POR_BIT];
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            clkloss_en_reg <= CLKLOSS_EN_RST;
        else if (enter)
            clkloss_en_reg <= CLKLOSS_EN_RST;
        else if (wr_rcr)
            clkloss_en_reg <= sfr_wdata[RCR_CLKLOSS_BIT];
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            cmp_en_reg <= CMP_EN_RST;
        else if (enter)
            cmp_en_reg <= CMP_EN_RST;
        else if (wr_rcr)
            cmp_en_reg <= sfr_wdata[RCR_CMP_BIT];
    end

    // Read data lags the address by one cycle
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= rd_mux;
    end

    rsc_clkloss #(
        .TIMEOUT_CYCLES (CLKLOSS_TIMEOUT)
    ) u_clkloss (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .enable    (clkloss_en_reg && running),
        .clk_level (system_clock_level),
        .timeout   (clkloss_timeout)
    );

    rsc_wdog #(
        .TICKS (WDOG_TICKS)
    ) u_wdog (
        .core_clk    (core_clk),
        .rst_b       (rst_b),
        .restart     (in_hold),
        .service     (wdog_service),
        .disable_req (wdog_disable),
        .enabled     (wdog_en),
        .expire      (wdog_expire)
    );

    assign sfr_rdata                = rdata_reg;
    assign rst_pin_out              = pin_out_reg;
    assign rst_pin_oe               = pin_oe_reg;
    assign supply_monitor_enable    = mon_en_reg;
    assign monitor_threshold_select = lvl_reg;
    assign watchdog_enabled         = wdog_en;
    assign sys_reset                = sys_reset_reg;

endmodule : rsc_top

// >>> dv/rsc_top_monitor.sv
/*
 * Port checker for the reset source controller.
 * Assumes it is bound to rsc_top and rst_b is the power-on reset.
 */
`timescale 1ns/1ps
module rsc_top_monitor
    import rsc_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rst_b,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic       rst_pin_in,
    input wire logic       rst_pin_out,
    input wire logic       rst_pin_oe,
    input wire logic       supply_above_threshold,
    input wire logic       supply_monitor_enable,
    input wire logic       monitor_threshold_select,
    input wire logic       watchdog_enabled,
    input wire logic       flash_access,
    input wire logic       flash_illegal,
    input wire logic       sys_reset
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    property p_unused;
        $past(sfr_addr) == SMC_ADDR |-> sfr_rdata[4:0] == SMC_UNUSED_VAL;
    endproperty
    a_unused: assert property (p_unused) else $error("Monitor low bits not zero");
    property p_status;
        $past(sfr_addr) == SMC_ADDR && !$past(sys_reset)
            |-> sfr_rdata[SMC_STAT_BIT] == $past(supply_above_threshold);
    endproperty
    a_status: assert property (p_status) else $error("Supply status not live");
    property p_reg;
        !sys_reset && sfr_wr && sfr_addr == SMC_ADDR |=> sys_reset ||
            (supply_monitor_enable == $past(sfr_wdata[SMC_EN_BIT]) &&
             monitor_threshold_select == $past(sfr_wdata[SMC_LVL_BIT]));
    endproperty
    a_reg: assert property (p_reg) else $error("Monitor control write lost");
    property p_sw;
        !sys_reset && sfr_wr && sfr_addr == RCR_ADDR && sfr_wdata[RCR_SW_BIT]
            |=> (sys_reset && !rst_pin_oe) [*8];
    endproperty
    a_sw: assert property (p_sw) else $error("Software reset wrong");
    property p_hold;
        $rose(sys_reset) |-> sys_reset [*8] ##1 sys_reset [*3];
    endproperty
    a_hold: assert property (p_hold) else $error("Reset held too briefly");
    property p_pin;
        !sys_reset && !rst_pin_in |=> sys_reset;
    endproperty
    a_pin: assert property (p_pin) else $error("Pin low gave no reset");
    property p_oe;
        rst_pin_oe |-> sys_reset && !rst_pin_out;
    endproperty
    a_oe: assert property (p_oe) else $error("Pin driven outside reset");
    property p_ill;
        !sys_reset && flash_illegal |=> sys_reset;
    endproperty
    a_ill: assert property (p_ill) else $error("Illegal flash gave no reset");
    property p_facc;
        !sys_reset && flash_access && !monitor_threshold_select |=> sys_reset;
    endproperty
    a_facc: assert property (p_facc) else $error("Unprotected flash gave no reset");
    property p_wdog;
        $fell(sys_reset) |-> watchdog_enabled;
    endproperty
    a_wdog: assert property (p_wdog) else $error("Watchdog off after reset");
    property p_men;
        $rose(sys_reset) |-> $stable(supply_monitor_enable);
    endproperty
    a_men: assert property (p_men) else $error("Monitor enable changed by reset");
endmodule : rsc_top_monitor

// >>> dv/rsc_partner.sv
/*
 * Far side of the reset controller: reset pin network and watched clock.
 * Assumes the pin has a pull-up and both parties only ever pull it low.
 */
`timescale 1ns/1ps
module rsc_partner (
    input  wire logic core_clk,
    input  wire logic rst_pin_oe,
    input  wire logic rst_pin_out,
    input  wire logic ext_low,
    input  wire logic stall,
    output logic      rst_pin_in,
    output logic      system_clock_level
);
    // Wired-low pin, pull-up wins only when nobody pulls
    assign rst_pin_in = !(ext_low || (rst_pin_oe && !rst_pin_out));
    initial system_clock_level = 1'b0;
    // Frozen level mimics a stopped clock
    always @(negedge core_clk)
        if (!stall)
            system_clock_level <= !system_clock_level;
endmodule : rsc_partner

// >>> dv/rsc_top_test.sv
/*
 * Self-checking bench for rsc_top with shortened detector and watchdog counts.
 * Assumes rsc_partner and rsc_top_monitor are compiled beforehand.
 */
`timescale 1ns/1ps
module rsc_top_test;
    import rsc_pkg::*;
    localparam int SRC_BIT [8] = '{RCR_PIN_BIT, RCR_CLKLOSS_BIT, RCR_WDOG_BIT, RCR_SW_BIT,
                                   RCR_CMP_BIT, RCR_FERR_BIT, RCR_FERR_BIT, RCR_POR_BIT};
    logic        core_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  sfr_addr = 8'h00;
    logic        sfr_wr = 1'b0;
    logic [7:0]  sfr_wdata = 8'h00;
    logic        supply = 1'b1, cmp_out = 1'b1, svc = 1'b0, wdis = 1'b0, svc_on = 1'b1;
    logic        f_acc = 1'b0, f_ill = 1'b0, ext_low = 1'b0, stall = 1'b0;
    logic [7:0]  sfr_rdata, v;
    logic        rst_pin_in, rst_pin_out, rst_pin_oe, clk_lvl, mon_en, thr_sel, wd_en;
    logic        sys_reset;
    logic [31:0] seed = 32'h5146;
    int          bad_count = 0;
    int          checks = 0;

    always #4 core_clk = ~core_clk;
    // Service pulses every other cycle keep the watchdog quiet
    always @(negedge core_clk)
        svc <= svc_on && !svc;

    rsc_top #(.CLKLOSS_TIMEOUT(20), .WDOG_TICKS(4)) i_dut (
        .core_clk, .rst_b, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata, .rst_pin_in,
        .rst_pin_out, .rst_pin_oe, .supply_above_threshold(supply),
        .supply_monitor_enable(mon_en), .monitor_threshold_select(thr_sel),
        .comparator_out(cmp_out), .system_clock_level(clk_lvl), .wdog_service(svc),
        .wdog_disable(wdis), .watchdog_enabled(wd_en), .flash_access(f_acc),
        .flash_illegal(f_ill), .sys_reset
    );
    rsc_partner i_far (
        .core_clk, .rst_pin_oe, .rst_pin_out, .ext_low, .stall, .rst_pin_in,
        .system_clock_level(clk_lvl)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic logic [7:0] exp_smc(input logic [7:0] w, input logic s);
        return {w[SMC_EN_BIT], s, w[SMC_LVL_BIT], SMC_UNUSED_VAL};
    endfunction : exp_smc

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic conclude;
        $display("Counts: checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge core_clk);
        sfr_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        sfr_addr = a;
        @(negedge core_clk);
        d = sfr_rdata;
    endtask : rd
    task automatic wait_lvl(input logic lvl);
        int n;
        n = 0;
        while (sys_reset !== lvl && n < 300)
        begin
            @(negedge core_clk);
            n++;
        end
        if (n == 300)
        begin
            bad_count++;
            conclude();
        end
    endtask : wait_lvl

    initial
    begin
        repeat (3) @(negedge core_clk);
        rst_b = 1'b1;
        wait_lvl(1'b0);
        rd(RCR_ADDR, v);
        chk(v, 8'h01 << RCR_POR_BIT);
        rd(SMC_ADDR, v);
        chk(v, exp_smc(8'h80, 1'b1));
        chk({7'h00, wd_en}, 8'h01);
        repeat (16)
        begin
            seed = xs(seed);
            wr(SMC_ADDR, seed[7:0]);
            rd(SMC_ADDR, v);
            chk(v, exp_smc(seed[7:0], supply));
            rd({1'b0, seed[14:8]}, v);
            chk(v, 8'h00);
        end
        wr(SMC_ADDR, 8'hA0);
        f_acc = 1'b1;
        @(negedge core_clk);
        f_acc = 1'b0;
        repeat (2) @(negedge core_clk);
        chk({7'h00, sys_reset}, 8'h00);
        wdis = 1'b1;
        @(negedge core_clk);
        wdis = 1'b0;
        @(negedge core_clk);
        chk({7'h00, wd_en}, 8'h00);
        wr(SMC_ADDR, 8'h00);
        wr(RCR_ADDR, 8'h12);
        wait_lvl(1'b1);
        wait_lvl(1'b0);
        chk({7'h00, wd_en}, 8'h01);
        rd(SMC_ADDR, v);
        chk(v, exp_smc(8'h00, supply));
        // Enable first; selection is already in place
        wr(SMC_ADDR, 8'h80);
        for (int k = 0; k < 8; k++)
        begin
            seed = xs(seed);
            case (k)
                1: wr(RCR_ADDR, 8'h06);
                3: wr(RCR_ADDR, 8'h12);
                4: wr(RCR_ADDR, 8'h22);
                default: @(negedge core_clk);
            endcase
            ext_low = (k == 0);
            stall = (k == 1);
            svc_on = (k != 2);
            cmp_out = (k != 4);
            f_ill = (k == 5);
            f_acc = (k == 6);
            supply = (k != 7);
            @(negedge core_clk);
            f_ill = 1'b0;
            f_acc = 1'b0;
            wait_lvl(1'b1);
            chk({7'h00, rst_pin_oe}, {7'h00, k == 7});
            // Up to 15 cycles, so level sources sometimes outlast the hold count
            repeat (seed[3:0]) @(negedge core_clk);
            ext_low = 1'b0;
            stall = 1'b0;
            svc_on = 1'b1;
            cmp_out = 1'b1;
            supply = 1'b1;
            wait_lvl(1'b0);
            rd(RCR_ADDR, v);
            chk(v, 8'h01 << SRC_BIT[k]);
        end
        rd(SMC_ADDR, v);
        chk(v, exp_smc(8'h80, 1'b1));
        conclude();
    end
endmodule : rsc_top_test

bind rsc_top rsc_top_monitor i_mon (
    .core_clk, .rst_b, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata, .rst_pin_in,
    .rst_pin_out, .rst_pin_oe, .supply_above_threshold, .supply_monitor_enable,
    .monitor_threshold_select, .watchdog_enabled, .flash_access, .flash_illegal, .sys_reset
);
